// ---- inc/lane_test_pkg.sv ----
// Purpose: Shared constants and carriers for the serial lane output control.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Register offsets are byte addresses; field positions are bit indices.
package lane_test_pkg;

  localparam int NUM_LANES = 8;
  localparam int HALF_LANES = 4;
  localparam int SAMPLE_W = 9;
  localparam int PAD_W = 3;
  localparam int WORD_W = 12;
  localparam int BLOCK_BITS = 24;
  localparam int LFSR_W = 31;

  localparam logic [4:0] BIT_LAST = 5'h17;
  localparam logic [3:0] CLK_PAT_LAST = 4'hF;
  localparam logic [2:0] OCTET_LAST = 3'h7;

  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;

  localparam int CTRL_LINK_EN = 0;
  localparam int CTRL_PD_MODE = 1;
  localparam int CTRL_DUAL = 2;
  localparam int CTRL_LANE_SET = 3;
  localparam int CTRL_SYNC_FEC = 4;
  localparam int CTRL_TEST_LO = 5;
  localparam int CTRL_TEST_HI = 7;
  localparam int CTRL_FMT_LO = 8;
  localparam int CTRL_FMT_HI = 12;

  localparam int STAT_PD = 0;
  localparam int STAT_ALT = 1;
  localparam int STAT_BYPASS = 2;
  localparam int STAT_FMT_OK = 3;
  localparam int STAT_ACTIVE = 4;

  localparam logic [4:0] FMT_9B_66B = 5'h0F;
  localparam logic [4:0] FMT_RESET = 5'h0F;

  // Lane seeds are small and distinct, so every width stays nonzero.
  localparam logic [30:0] SEED_BASE = 31'h0000_0001;

  typedef enum logic [2:0] {
    TEST_OFF = 3'h0,
    TEST_PRBS7 = 3'h1,
    TEST_PRBS9 = 3'h2,
    TEST_PRBS15 = 3'h3,
    TEST_PRBS23 = 3'h4,
    TEST_PRBS31 = 3'h5,
    TEST_CLOCK = 3'h6,
    TEST_RAMP = 3'h7
  } test_sel_t;

  typedef struct packed {
    logic [NUM_LANES-1:0][SAMPLE_W-1:0] chan_a;
    logic [NUM_LANES-1:0][SAMPLE_W-1:0] chan_b;
  } sample_block_t;

  typedef struct packed {
    logic [NUM_LANES-1:0] data;
    logic [NUM_LANES-1:0] enable;
  } lane_out_t;

endpackage

// ---- tb/lane_output_ctrl_checker.sv ----
// Purpose: Port-level assertions for the lane output control.
// Assumes: Single pclk domain, presetn active low.
// Notes: Power-down is given four cycles to reach the lane drivers.
`timescale 1ns/1ps
module lane_output_ctrl_checker
  import lane_test_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic power_down_pin,
  input wire logic sample_ready,
  input wire lane_out_t lanes,
  input wire logic link_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_req;
    psel && penable && !pready;
  endsequence
  sequence s_pd;
    power_down_pin [*4];
  endsequence
  sequence s_quiet;
    !sample_ready [*8];
  endsequence
  AST_APB_ANSWER: assert property (s_req |=> pready)
    else $error("access not answered");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  AST_PD_DRIVERS: assert property (s_pd |-> lanes.enable == 8'h00)
    else $error("drivers on in power-down");
  AST_PD_IDLE: assert property (s_pd |-> !link_active && !sample_ready)
    else $error("link runs in power-down");
  AST_SETS_EXCL: assert property (lanes.enable inside {8'h00, 8'h0F, 8'hF0,
    8'hFF})
    else $error("lane sets mixed");
  AST_BLOCK_SPACING: assert property (sample_ready |=> s_quiet)
    else $error("blocks taken too close");
endmodule // lane_output_ctrl_checker

bind lane_output_ctrl lane_output_ctrl_checker chk_i (.pclk, .presetn, .psel,
  .penable, .prdata, .pready, .pslverr, .power_down_pin, .sample_ready,
  .lanes, .link_active);

// ---- tb/lane_rx_model.sv ----
// Purpose: Receiver side that self-synchronises to the lane PRBS streams.
// Assumes: The bench tells the model which test pattern is running.
// Notes: Lane 0 enable stands for the whole link being up.
`timescale 1ns/1ps
module lane_rx_model
  import lane_test_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire lane_out_t lanes,
  input wire logic [2:0] mode,
  output int bad,
  output logic dup
);
  logic [LFSR_W-1:0] h [NUM_LANES];
  logic [2:0] last;
  int cnt;
  int a;
  int b;
  always @(posedge pclk or negedge presetn) begin
    case (mode)
      3'h1: {a, b} = {32'd6, 32'd7};
      3'h2: {a, b} = {32'd5, 32'd9};
      3'h3: {a, b} = {32'd14, 32'd15};
      3'h4: {a, b} = {32'd18, 32'd23};
      3'h5: {a, b} = {32'd28, 32'd31};
      default: {a, b} = {32'd0, 32'd1};
    endcase
    if (!presetn) begin
      bad <= 0;
      dup <= 0;
      cnt <= 0;
    end else if (lanes.enable[0] !== 1'b1 || mode !== last) begin
      // Stale bits after a relink are dropped until history refills.
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
      for (int l = 0; l < NUM_LANES; l++) begin
        h[l] <= {h[l][LFSR_W-2:0], lanes.data[l]};
        if (cnt >= 31 && a > 0 && lanes.data[l] !== (h[l][a-1] ^ h[l][b-1]))
          bad <= bad + 1;
        for (int j = l + 1; j < NUM_LANES; j++)
          if (cnt >= 31 && a > 0 && h[l] == h[j]) dup <= 1;
      end
    end
    last <= mode;
  end
endmodule // lane_rx_model

// ---- tb/serial_lane_output_test_control_tb_top.sv ----
// Purpose: Self-checking bench for the lane output control block.
// Assumes: Lane bits start one edge after the edge that takes a block.
// Notes: Expected lane words are built from the samples the bench drives.
`timescale 1ns/1ps
module serial_lane_output_test_control_tb_top;
  import lane_test_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic power_down_pin = 0;
  logic sample_valid = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, b;
  logic pready, pslverr, err, sample_ready, link_bypass;
  logic sync_fec_select, link_active, dup;
  logic [2:0] mode = 3'h0;
  logic [159:0] rnd;
  sample_block_t samples = '0;
  lane_out_t lanes;
  int num_errors = 0, checked = 0, seed = 39673, bad, n;
  always #4 pclk = ~pclk;
  lane_output_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .power_down_pin, .sample_valid,
    .samples, .sample_ready, .lanes, .link_bypass, .sync_fec_select,
    .link_active);
  lane_rx_model rx (.pclk, .presetn, .lanes, .mode, .bad, .dup);
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task print_verdict;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (k >= 20) num_errors++;
  endtask
  function automatic logic [31:0] cw(logic [2:0] t, logic [4:0] f);
    return {19'h0, FMT_9B_66B, t, f};
  endfunction
  task lane_data(input logic alt);
    logic [23:0] w [8];
    logic [7:0] e, m;
    rnd = {$random(seed), $random(seed), $random(seed), $random(seed),
      $random(seed)};
    samples <= rnd[143:0];
    sample_valid <= 1;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (sample_ready !== 1'b1 && n < 100);
    if (n >= 100) num_errors++;
    for (int k = 0; k < 4; k++) begin
      w[k] = {samples.chan_a[k], 3'h0, samples.chan_a[k+4], 3'h0};
      w[k+4] = {samples.chan_b[k], 3'h0, samples.chan_b[k+4], 3'h0};
    end
    m = alt ? 8'hF0 : 8'hFF;
    @(posedge pclk);
    for (int i = 23; i >= 0; i--) begin
      @(posedge pclk);
      #1;
      for (int l = 0; l < 8; l++) e[l] = alt ? (l > 3) & w[l%4][i] : w[l][i];
      chk(32'(lanes.enable), 32'(m), "enable");
      chk(32'(lanes.data & m), 32'(e), "data");
    end
    sample_valid <= 0;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h0000_0F00, "ctrl_reset");
    apb(0, 12'h008, 32'h0);
    chk(32'(err), 32'h1, "unmapped_err");
    chk(rd, 32'h0, "unmapped_data");
    apb(1, CTRL_ADDR, cw(TEST_OFF, 5'h0D));
    lane_data(0);
    apb(0, STATUS_ADDR, 32'h0);
    chk(32'(rd[STAT_ALT]), 32'h0, "alt_dual");
    chk(32'(sync_fec_select), 32'h0, "crc");
    apb(1, CTRL_ADDR, cw(TEST_OFF, 5'h19));
    lane_data(1);
    chk(32'(sync_fec_select), 32'h1, "fec");
    @(posedge pclk);
    power_down_pin <= 1;
    repeat (6) @(posedge pclk);
    #1;
    chk(32'({lanes, link_active}), 32'h0, "pd_pin");
    apb(0, CTRL_ADDR, 32'h0);
    chk(rd, cw(TEST_OFF, 5'h19), "ctrl_kept");
    power_down_pin <= 0;
    apb(1, CTRL_ADDR, cw(TEST_OFF, 5'h07));
    repeat (6) @(posedge pclk);
    apb(0, STATUS_ADDR, 32'h0);
    chk(32'({rd[STAT_PD], lanes.enable}), 32'h100, "pd_cmd");
    apb(1, CTRL_ADDR, cw(TEST_OFF, 5'h04));
    for (int t = 1; t < 8; t++) begin
      apb(1, CTRL_ADDR, cw(3'(t), 5'h04));
      mode <= 3'(t);
      apb(1, CTRL_ADDR, cw(3'(t), 5'h05));
      repeat (120) @(posedge pclk);
      #1;
      chk(32'(lanes.enable), 32'hFF, "test_lanes");
      chk(32'(link_bypass), 32'(t < 7), "bypass");
      chk(32'(bad), 32'h0, "prbs");
      chk(32'(dup), 32'h0, "phase");
      n = 0;
      for (int i = 0; i < 32; i++) begin
        @(posedge pclk);
        #1;
        b[i] = lanes.data[0];
        if (t == 7) chk(32'(lanes.data inside {8'h00, 8'hFF}), 1, "ramp");
      end
      for (int i = 0; i < 16; i++) n += 32'(b[i] != b[i+1]);
      if (t == 6) chk({b[31:16], b[15:8], 8'(n)}, {b[15:0], ~b[7:0], 8'h2},
        "clock");
      apb(1, CTRL_ADDR, cw(3'(t), 5'h04));
    end
    print_verdict;
  end
  initial begin
    #200000;
    num_errors++;
    print_verdict;
  end
endmodule // serial_lane_output_test_control_tb_top

// ---- verilog/lane_output_ctrl.sv ----
// Purpose: Lane mapping, redundancy, power-down and test patterns for a
//   multi-lane serial transmitter, one serial bit per lane per clock.
// Assumes: Sample inputs are synchronous to pclk; the link layer outside
//   encodes and scrambles unless told to bypass.
// Notes: Configuration lives in APB registers that no power-down touches.
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps

// Operation
// - 9-bit samples padded with 000; lane k sends sample k then k+4.
// - Sync header protection offers CRC-12 only, no CRC-3 variant.
// - FEC is the alternative sync header protection mode.
// - Redundant lane output only allowed for formats of four lanes or less.
// - Lane set select 0 drives D3-D0, 1 drives D7-D4.
// - Default and alternate lane sets never run together.
// - Power-down pin high powers down and disables lane drivers.
// - Registers and calibration survive power-down.
// - Power-down may also be commanded by the mode register.
// - Test pattern select picks the active lane test pattern.
// - Test modes keep lane count and rate set by output format mode.
// - PRBS modes bypass transport and link layers.
// - PRBS7 bit is XOR of bits 6 and 7 back, period 127.
// - PRBS9 bit is XOR of bits 5 and 9 back, period 511.
// - PRBS15 bit is XOR of bits 14 and 15 back, period 32767.
// - PRBS23 bit is XOR of bits 18 and 23 back, period 8388607.
// - PRBS31 bit is XOR of bits 28 and 31 back, long period.
// - Every lane starts its PRBS at a distinct phase.
// - PRBS sequences follow the standard test pattern recommendation.
// - Clock pattern bypasses layers, repeating eight ones then eight zeros.
// - Ramp sends identical octets 00 to FF on all lanes via link layer.
module lane_output_ctrl
  import lane_test_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_down_pin,
  input wire logic sample_valid,
  input wire sample_block_t samples,
  output logic sample_ready,
  output lane_out_t lanes,
  output logic link_bypass,
  output logic sync_fec_select,
  output logic link_active
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DOWN = 3'b100
  } tx_state_t;

  typedef struct packed {
    tx_state_t st;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic link_en;
    logic pd_mode;
    logic dual;
    logic lane_set_select;
    logic sync_fec;
    test_sel_t test_pattern_select;
    logic [4:0] output_format_mode;
    logic [4:0] bitcnt;
    logic [3:0] clk_phase;
    logic [7:0] ramp;
    logic [2:0] ramp_bit;
    logic [NUM_LANES-1:0][BLOCK_BITS-1:0] shreg;
    logic [NUM_LANES-1:0][LFSR_W-1:0] lfsr;
    test_sel_t last_test;
    logic sample_ready;
    lane_out_t lanes;
    logic bypass;
  } state_t;

  state_t r;
  state_t next_r;

  logic [NUM_LANES-1:0][LFSR_W-1:0] lfsr_step;
  logic [NUM_LANES-1:0] prbs_bit;
  logic [NUM_LANES-1:0][BLOCK_BITS-1:0] block_load;
  logic powered_down;
  logic alt_active;
  logic fmt_ok;
  logic is_prbs;
  logic reseed;
  logic [3:0] lane_count;

  function automatic logic prbs_feedback(input test_sel_t sel,
                                         input logic [LFSR_W-1:0] s);
    logic fb;
    fb = 1'b0;
    // Bit 0 holds the previous bit, so bit i-1 is i positions back.
    unique case (sel)
      TEST_PRBS7: fb = s[5] ^ s[6];
      TEST_PRBS9: fb = s[4] ^ s[8];
      TEST_PRBS15: fb = s[13] ^ s[14];
      TEST_PRBS23: fb = s[17] ^ s[22];
      TEST_PRBS31: fb = s[27] ^ s[30];
      default: fb = 1'b0;
    endcase
    return fb;
  endfunction

  assign is_prbs = (r.test_pattern_select == TEST_PRBS7) ||
                   (r.test_pattern_select == TEST_PRBS9) ||
                   (r.test_pattern_select == TEST_PRBS15) ||
                   (r.test_pattern_select == TEST_PRBS23) ||
                   (r.test_pattern_select == TEST_PRBS31);
  assign powered_down = power_down_pin | r.pd_mode;
  assign fmt_ok = (r.output_format_mode == FMT_9B_66B);
  // Redundancy is only honoured in the four-lane single channel case.
  assign alt_active = r.lane_set_select & ~r.dual;
  assign lane_count = r.dual ? 4'h8 : 4'h4;
  // A pattern change or a stopped link restarts the generators.
  assign reseed = (r.test_pattern_select != r.last_test) ||
                  (r.st != ST_RUN);

  genvar g;
  generate
    for (g = 0; g < NUM_LANES; g++) begin : g_lane
      localparam int SRC = g % HALF_LANES;
      logic fb;
      assign fb = prbs_feedback(r.test_pattern_select, r.lfsr[g]);
      assign prbs_bit[g] = fb;
      assign lfsr_step[g] = reseed ?
        (SEED_BASE + LFSR_W'(g)) :
        {r.lfsr[g][LFSR_W-2:0], fb};
      // Lanes 0-3 carry channel A, lanes 4-7 channel B.
      if (g < HALF_LANES) begin : g_a
        assign block_load[g] = {samples.chan_a[SRC], {PAD_W{1'b0}},
          samples.chan_a[SRC + HALF_LANES], {PAD_W{1'b0}}};
      end else begin : g_b
        assign block_load[g] = {samples.chan_b[SRC], {PAD_W{1'b0}},
          samples.chan_b[SRC + HALF_LANES], {PAD_W{1'b0}}};
      end
    end
  endgenerate

  always_comb begin
    logic [NUM_LANES-1:0] logical_bit;
    logic [NUM_LANES-1:0] logical_en;
    logic access;
    logic hit_ctrl;
    logic hit_stat;
    logical_bit = '0;
    logical_en = '0;
    next_r = r;

    // APB slave: one wait state, answer registered.
    access = psel & penable & ~r.pready;
    hit_ctrl = (paddr == CTRL_ADDR);
    hit_stat = (paddr == STATUS_ADDR);
    next_r.pready = access;
    next_r.pslverr = access & ~hit_ctrl & ~hit_stat;
    next_r.prdata = '0;
    if (access && !pwrite && hit_ctrl) begin
      next_r.prdata[CTRL_LINK_EN] = r.link_en;
      next_r.prdata[CTRL_PD_MODE] = r.pd_mode;
      next_r.prdata[CTRL_DUAL] = r.dual;
      next_r.prdata[CTRL_LANE_SET] = r.lane_set_select;
      next_r.prdata[CTRL_SYNC_FEC] = r.sync_fec;
      next_r.prdata[CTRL_TEST_HI:CTRL_TEST_LO] = r.test_pattern_select;
      next_r.prdata[CTRL_FMT_HI:CTRL_FMT_LO] = r.output_format_mode;
    end
    if (access && !pwrite && hit_stat) begin
      next_r.prdata[STAT_PD] = powered_down;
      next_r.prdata[STAT_ALT] = alt_active;
      next_r.prdata[STAT_BYPASS] = r.bypass;
      next_r.prdata[STAT_FMT_OK] = fmt_ok;
      next_r.prdata[STAT_ACTIVE] = (r.st == ST_RUN);
    end
    if (access && pwrite && hit_ctrl) begin
      next_r.link_en = pwdata[CTRL_LINK_EN];
      next_r.pd_mode = pwdata[CTRL_PD_MODE];
      next_r.dual = pwdata[CTRL_DUAL];
      next_r.lane_set_select = pwdata[CTRL_LANE_SET];
      // Clear selects CRC-12; no short CRC exists to pick.
      next_r.sync_fec = pwdata[CTRL_SYNC_FEC];
      next_r.test_pattern_select =
        test_sel_t'(pwdata[CTRL_TEST_HI:CTRL_TEST_LO]);
      next_r.output_format_mode = pwdata[CTRL_FMT_HI:CTRL_FMT_LO];
    end

    // Power-down only stops the lanes; configuration stays put.
    unique case (r.st)
      ST_IDLE: begin
        if (powered_down) begin
          next_r.st = ST_DOWN;
        end else if (r.link_en && fmt_ok) begin
          next_r.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (powered_down) begin
          next_r.st = ST_DOWN;
        end else if (!r.link_en || !fmt_ok) begin
          next_r.st = ST_IDLE;
        end
      end
      ST_DOWN: begin
        // The far end must relink and flush stale data on leaving here.
        if (!powered_down) begin
          next_r.st = ST_IDLE;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase

    next_r.last_test = r.test_pattern_select;
    next_r.lfsr = lfsr_step;

    if (r.st == ST_RUN) begin
      next_r.bitcnt = (r.bitcnt == BIT_LAST) ? '0 : r.bitcnt + 5'h01;
      next_r.clk_phase = r.clk_phase + 4'h1;
      next_r.ramp_bit = r.ramp_bit + 3'h1;
      if (r.ramp_bit == OCTET_LAST) begin
        next_r.ramp = r.ramp + 8'h01;
      end
    end else begin
      next_r.bitcnt = '0;
      next_r.clk_phase = '0;
      next_r.ramp_bit = '0;
      next_r.ramp = '0;
    end

    // A new block is accepted at the start of each 24-bit lane frame except the first after entering ST_RUN.
    for (int l = 0; l < NUM_LANES; l++) begin
      if (r.st == ST_RUN && r.bitcnt == '0) begin
        next_r.shreg[l] = (sample_valid && r.sample_ready) ?
          block_load[l] : '0;
      end else begin
        next_r.shreg[l] = {r.shreg[l][BLOCK_BITS-2:0], 1'b0};
      end
    end
    next_r.sample_ready = (r.st == ST_RUN) && (next_r.bitcnt == '0);

    for (int l = 0; l < NUM_LANES; l++) begin
      unique case (r.test_pattern_select)
        TEST_OFF: logical_bit[l] = r.shreg[l][BLOCK_BITS-1];
        TEST_CLOCK: logical_bit[l] = ~r.clk_phase[3];
        TEST_RAMP: logical_bit[l] = r.ramp[3'h7 - r.ramp_bit];
        default: logical_bit[l] = prbs_bit[l];
      endcase
      logical_en[l] = (r.st == ST_RUN) && (4'(l) < lane_count);
    end

    // Four logical lanes land on exactly one physical set.
    if (alt_active) begin
      next_r.lanes.data = {logical_bit[HALF_LANES-1:0], 4'h0};
      next_r.lanes.enable = {logical_en[HALF_LANES-1:0], 4'h0};
    end else begin
      next_r.lanes.data = logical_bit;
      next_r.lanes.enable = logical_en;
    end
    if (powered_down) begin
      next_r.lanes = '0;
    end
    next_r.bypass = is_prbs ||
      (r.test_pattern_select == TEST_CLOCK);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.test_pattern_select <= TEST_OFF;
      r.last_test <= TEST_OFF;
      r.output_format_mode <= FMT_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign sample_ready = r.sample_ready;
  assign lanes = r.lanes;
  assign link_bypass = r.bypass;
  assign sync_fec_select = r.sync_fec;
  assign link_active = (r.st == ST_RUN);

endmodule // lane_output_ctrl
